// ---- rtl/secreg_flash.v ----
/*
  Serial flash command sequencer for unique ID, security space and deep power-down.
  Assumes SPI mode 0 from an outside host; chip select, clock and data are
  asynchronous pins sampled by clk, which must run well above the serial clock.
*/
// Overview of operation
// - Unique ID: address, dummy, then 128 bits out
// - Separate 512-byte security space, own commands
// - Erase needs latch, ends exactly after address
// - Self-timed cycle shows write-in-progress high
// - Write enable latch cleared by cycle end
// - Lock bit set ignores erase
// - Program needs latch and one data byte
// - Lock bit set ignores program
// - Program behaves like page program, two pages
// - Read: address, dummy, data on falling edges
// - Read address wraps at 1FFh to zero
// - Power-down opcode must end exactly at bit eight
// - Entry delay before power-down state
// - In power-down only release and reset act
// - Power-down rejected during running cycle
// - Deselect gives standby, not power-down
// - Reset always starts in standby
// - Release alone, then release delay
// - Release with dummies streams device ID
// - Release with ID uses second delay
// - Release ignored while write in progress
`timescale 1ns/1ns
`include "secreg_consts.vh"
module secreg_flash
#(
  parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978, // Arbitrary value.
  parameter [7:0]   DEVICE_ID = 8'h5A                                  // Arbitrary value.
)
(
  input  wire       clk,
  input  wire       rst,
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       mosi,
  input  wire       lock_set,
  output reg        miso,
  output reg        miso_oe,
  output reg        write_in_progress,
  output reg        write_enable_latch,
  output reg        security_lock_bit,
  output reg        deep_power_down
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg  [1:0]  cs_sync;            // Chip select synchroniser.
  reg  [1:0]  ck_sync;            // Serial clock synchroniser.
  reg  [1:0]  di_sync;            // Data-in synchroniser.
  reg  [1:0]  lk_sync;            // Lock strap synchroniser.
  reg         ck_last;            // Previous synchronised clock.
  reg         cs_last;            // Previous synchronised select.
  wire        cs_n_s = cs_sync[1];
  wire        rise   = ck_sync[1] & ~ck_last & ~cs_n_s;
  wire        fall   = ~ck_sync[1] & ck_last & ~cs_n_s;
  wire        cs_up  = cs_n_s & ~cs_last;
  wire        cs_dn  = ~cs_n_s & cs_last;

  // Only the second stage of each pair is read by logic.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h0;
      di_sync <= 2'h0;
      lk_sync <= 2'h0;
      ck_last <= 1'b0;
      cs_last <= 1'b1;
    end
    else
    begin
      cs_sync <= {cs_sync[0], cs_n};
      ck_sync <= {ck_sync[0], sclk};
      di_sync <= {di_sync[0], mosi};
      lk_sync <= {lk_sync[0], lock_set};
      ck_last <= ck_sync[1];
      cs_last <= cs_sync[1];
    end
  end

  // ****************************************************************
  // Storage and the two-entry output byte buffer
  // ****************************************************************
  reg  [7:0]  mem [0:`SEC_BYTES-1];  // Security space, flip-flops.
  reg  [7:0]  page [0:`SEC_BYTES-1]; // Program latch, like a page buffer.
  reg  [`SEC_BYTES-1:0] page_mark;   // Bytes loaded into the latch.
  reg  [7:0]  fifo [0:1];            // Output byte buffer.
  reg         wp, rp;                // Buffer pointers.
  reg  [1:0]  fcnt;                  // Buffer fill.
  wire        f_full  = (fcnt == 2'h2);
  wire        f_empty = (fcnt == 2'h0);

  // ****************************************************************
  // Command decoder state
  // ****************************************************************
  localparam ST_OP   = 3'h0;  // Collecting opcode.
  localparam ST_ADDR = 3'h1;  // Collecting address.
  localparam ST_DUMY = 3'h2;  // Skipping dummy bytes.
  localparam ST_OUT  = 3'h3;  // Streaming output.
  localparam ST_DATA = 3'h4;  // Collecting program data.
  localparam ST_IGN  = 3'h5;  // Ignoring the rest of the frame.
  localparam integer ERASE_TICKS      = `ERASE_CYC;      // Erase cycle, cut to timer width at use.
  localparam integer PROGRAM_TICKS    = `PROGRAM_CYC;    // Program cycle length in clocks.
  localparam integer DP_ENTRY_TICKS   = `DP_ENTRY_CYC;   // Power-down entry delay in clocks.
  localparam integer RELEASE_TICKS    = `RELEASE_CYC;    // Plain release delay in clocks.
  localparam integer RELEASE_ID_TICKS = `RELEASE_ID_CYC; // Release-with-ID delay in clocks.

  reg  [2:0]  state;
  reg  [7:0]  op;             // Opcode of this frame.
  reg  [7:0]  sh;             // Input shift register.
  reg  [2:0]  bitn;           // Bit within byte.
  reg  [1:0]  bcnt;           // Byte counter for address and dummies.
  reg  [8:0]  addr;           // Security byte address.
  reg  [6:0]  idx;            // Unique ID byte fetch index.
  reg         exact;          // Frame ended on a byte boundary after its last byte.
  reg         got_data;       // Program frame carried data.
  reg  [7:0]  osh;            // Output shift register.
  reg  [2:0]  obit;           // Output bit counter.
  reg         ovalid;         // Output shift register holds a byte.
  reg  [1:0]  busy;           // 0 idle, 1 erase, 2 program.
  reg  [15:0] tmr;            // Shared delay timer.
  reg         dp_pend;        // Power-down entry pending.
  reg         rel_pend;       // Release delay pending.
  reg         refused;        // Opcode refused: at deselect the frame may change no state, except that a program opcode clears page_mark.
  wire [7:0]  byte_in = {sh[6:0], di_sync[1]};
  integer     i;

  // Source byte for the output buffer for the current opcode.
  function [7:0] src_byte;
    input [7:0] opc;
    input [8:0] a;
    input [6:0] k;
    begin
      if (opc == `OP_SEC_READ)
        src_byte = mem[a];
      else if (opc == `OP_UNIQUE_ID)
        src_byte = UNIQUE_ID[127 - {k[3:0], 3'h0} -: 8];
      else if (opc == `OP_READ_STATUS)
        src_byte = {security_lock_bit, 5'h00, write_enable_latch, write_in_progress};
      else
        src_byte = DEVICE_ID;
    end
  endfunction

  // Whole sequencer: decoding, buffer, shifter and self-timed cycles.
  // One process keeps every flag single-driven at the cost of length.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_OP; op <= 8'h00; sh <= 8'h00; bitn <= 3'h0; bcnt <= 2'h0;
      addr <= 9'h000; idx <= 7'h00; exact <= 1'b0; got_data <= 1'b0;
      osh <= 8'h00; obit <= 3'h0; ovalid <= 1'b0; wp <= 1'b0; rp <= 1'b0;
      fcnt <= 2'h0; busy <= 2'h0; tmr <= 16'h0000; dp_pend <= 1'b0;
      rel_pend <= 1'b0; miso <= 1'b0; miso_oe <= 1'b0; refused <= 1'b0;
      write_in_progress <= 1'b0; write_enable_latch <= 1'b0;
      security_lock_bit <= 1'b0;
      deep_power_down <= 1'b0;
      fifo[0] <= 8'h00; fifo[1] <= 8'h00;
      page_mark <= {`SEC_BYTES{1'b0}};
      for (i = 0; i < `SEC_BYTES; i = i + 1)
      begin
        mem[i] <= `SEC_ERASED;
        page[i] <= `SEC_ERASED;
      end
    end
    else
    begin
      // The lock is one-time: once set it clears only on reset.
      if (lk_sync[1])
        security_lock_bit <= 1'b1;

      // Self-timed cycles and delays share one down-counter.
      if (tmr != 16'h0000)
        tmr <= tmr - 16'h0001;
      else if (busy == 2'h1)
      begin
        for (i = 0; i < `SEC_BYTES; i = i + 1)
          mem[i] <= `SEC_ERASED;
        busy <= 2'h0;
        write_in_progress <= 1'b0;
        write_enable_latch <= 1'b0;
      end
      else if (busy == 2'h2)
      begin
        // Programming only clears bits, as ordinary page programming does.
        for (i = 0; i < `SEC_BYTES; i = i + 1)
          if (page_mark[i])
            mem[i] <= mem[i] & page[i];
        page_mark <= {`SEC_BYTES{1'b0}};
        busy <= 2'h0;
        write_in_progress <= 1'b0;
        write_enable_latch <= 1'b0;
      end
      else if (dp_pend)
      begin
        dp_pend <= 1'b0;
        deep_power_down <= 1'b1;
      end
      else if (rel_pend)
        rel_pend <= 1'b0;

      // Output buffer: refill from the source while streaming.
      if (state == ST_OUT && !f_full && !cs_n_s)
      begin
        fifo[wp] <= src_byte(op, addr, idx);
        wp <= ~wp;
        if (op == `OP_SEC_READ)
          addr <= addr + 9'h001;
        idx <= idx + 7'h01;
      end
      if (!ovalid && !f_empty && !cs_n_s)
      begin
        osh <= fifo[rp];
        rp <= ~rp;
        ovalid <= 1'b1;
        obit <= 3'h0;
      end
      fcnt <= fcnt + ((state == ST_OUT && !f_full && !cs_n_s) ? 2'h1 : 2'h0)
                   - ((!ovalid && !f_empty && !cs_n_s) ? 2'h1 : 2'h0);

      // Output bits change on falling serial clock edges.
      if (fall && ovalid)
      begin
        miso <= osh[7];
        miso_oe <= 1'b1;
        osh <= {osh[6:0], 1'b0};
        obit <= obit + 3'h1;
        if (obit == 3'h7)
          ovalid <= 1'b0;
      end

      if (cs_dn)
      begin
        state <= ST_OP; bitn <= 3'h0; bcnt <= 2'h0; exact <= 1'b0;
        got_data <= 1'b0; ovalid <= 1'b0; fcnt <= 2'h0; wp <= 1'b0; rp <= 1'b0;
        idx <= 7'h00; refused <= 1'b0;
      end
      else if (rise)
      begin
        sh <= byte_in;
        bitn <= bitn + 3'h1;
        exact <= 1'b0;
        if (bitn == 3'h7)
        begin
          case (state)
            ST_OP:
            begin
              op <= byte_in;
              bcnt <= 2'h0;
              exact <= 1'b1;
              refused <= ((deep_power_down || dp_pend) && byte_in != `OP_RELEASE_ID
                          && byte_in != `OP_SOFT_RESET) || rel_pend
                          || write_in_progress;
              // While powered down or entering it, only release and reset get through; during the release delay nothing does.
              if ((deep_power_down || dp_pend) && byte_in != `OP_RELEASE_ID
                  && byte_in != `OP_SOFT_RESET)
                state <= ST_IGN;
              else if (rel_pend)
                state <= ST_IGN;
              else if (write_in_progress && byte_in != `OP_READ_STATUS)
                state <= ST_IGN;
              else if (byte_in == `OP_READ_STATUS)
                state <= ST_OUT;
              else if (byte_in == `OP_UNIQUE_ID || byte_in == `OP_SEC_READ ||
                       byte_in == `OP_SEC_ERASE || byte_in == `OP_SEC_PROGRAM)
                state <= ST_ADDR;
              else if (byte_in == `OP_RELEASE_ID)
                state <= ST_DUMY;
              else
                state <= ST_IGN;
            end
            ST_ADDR:
            begin
              // Upper address bits are the host's duty; only bits 8..0 count.
              if (bcnt == 2'h1)
                addr[8] <= byte_in[0];
              if (bcnt == 2'h2)
              begin
                addr[7:0] <= byte_in;
                bcnt <= 2'h0;
                exact <= 1'b1;
                if (op == `OP_SEC_PROGRAM)
                  state <= ST_DATA;
                else if (op == `OP_SEC_ERASE)
                  state <= ST_IGN;
                else
                  state <= ST_DUMY;
              end
              else
                bcnt <= bcnt + 2'h1;
            end
            ST_DUMY:
            begin
              bcnt <= bcnt + 2'h1;
              if (op != `OP_RELEASE_ID || bcnt == 2'h2)
                state <= ST_OUT;
            end
            ST_DATA:
            begin
              // Address wraps inside the page while loading the latch.
              page[addr] <= byte_in;
              page_mark[addr] <= 1'b1;
              addr <= {addr[8], addr[7:0] + 8'h01};
              got_data <= 1'b1;
            end
            default:
              state <= state;
          endcase
        end
      end
      else if (cs_up)
      begin
        miso_oe <= 1'b0;
        state <= ST_OP;
        // Deselect alone changes no mode; a refused opcode changes nothing, except that a refused program clears page_mark.
        // An erase must have all three address bytes, so it must sit in ST_IGN here.
        if (op == `OP_SEC_ERASE && exact && bitn == 3'h0 && write_enable_latch && !refused
            && state == ST_IGN && !security_lock_bit && !write_in_progress)
        begin
          busy <= 2'h1;
          write_in_progress <= 1'b1;
          tmr <= ERASE_TICKS[15:0];
        end
        else if (op == `OP_SEC_PROGRAM && got_data && bitn == 3'h0 && !refused &&
                 write_enable_latch && !security_lock_bit && !write_in_progress)
        begin
          busy <= 2'h2;
          write_in_progress <= 1'b1;
          tmr <= PROGRAM_TICKS[15:0];
        end
        else if (op == `OP_SEC_PROGRAM)
          page_mark <= {`SEC_BYTES{1'b0}};
        else if (op == `OP_POWER_DOWN && state == ST_IGN && exact && bitn == 3'h0 && !refused
                 && !write_in_progress && !deep_power_down)
        begin
          dp_pend <= 1'b1;
          tmr <= DP_ENTRY_TICKS[15:0];
        end
        else if (op == `OP_RELEASE_ID && deep_power_down && !write_in_progress && !refused)
        begin
          deep_power_down <= 1'b0;
          rel_pend <= 1'b1;
          tmr <= (state == ST_OUT) ? RELEASE_ID_TICKS[15:0] : RELEASE_TICKS[15:0];
        end
        else if (op == `OP_SOFT_RESET && state == ST_IGN && !write_in_progress && !refused)
        begin
          deep_power_down <= 1'b0;
          dp_pend <= 1'b0;
          write_enable_latch <= 1'b0;
        end
        else if (op == `OP_WRITE_ENABLE && state == ST_IGN && exact && !refused)
          write_enable_latch <= 1'b1;
        else if (op == `OP_WRITE_DISABLE && state == ST_IGN && exact && !refused)
          write_enable_latch <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/secreg_consts.vh ----
/*
  Constants for the security-space and power-down command sequencer.
  Assumes it is included by bare name from the sequencer source.
*/
`ifndef SECREG_CONSTS_VH
`define SECREG_CONSTS_VH
`define OP_UNIQUE_ID      8'h4B
`define OP_SEC_ERASE      8'h44
`define OP_SEC_PROGRAM    8'h42
`define OP_SEC_READ       8'h48
`define OP_POWER_DOWN     8'hB9
`define OP_RELEASE_ID     8'hAB
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05
`define OP_SOFT_RESET     8'h99
`define SEC_BYTES         512
`define SEC_ERASED        8'hFF
`define CLK_NS            50
`define ERASE_NS          2000
`define PROGRAM_NS        1000
`define DP_ENTRY_NS       3000
`define RELEASE_NS        3000
`define RELEASE_ID_NS     3000
`define ERASE_CYC         ((`ERASE_NS + `CLK_NS - 1) / `CLK_NS)
`define PROGRAM_CYC       ((`PROGRAM_NS + `CLK_NS - 1) / `CLK_NS)
`define DP_ENTRY_CYC      ((`DP_ENTRY_NS + `CLK_NS - 1) / `CLK_NS)
`define RELEASE_CYC       ((`RELEASE_NS + `CLK_NS - 1) / `CLK_NS)
`define RELEASE_ID_CYC    ((`RELEASE_ID_NS + `CLK_NS - 1) / `CLK_NS)
`define STAT_WIP          0
`define STAT_WEL          1
`define STAT_LOCK         7
`endif

// ---- testbench/spi_host_model.sv ----
/*
  Behavioural SPI host (mode 0) that drives chip select, serial clock and data.
  Assumes a fast system clock; each serial half period is four of its cycles.
*/
`timescale 1ns/1ns
module spi_host_model (
  input  wire       clk,
  input  wire       miso,
  output reg        cs_n,
  output reg        sclk,
  output reg        mosi
);
  // Bits seen on the data-out line, newest in bit zero.
  reg [127:0] rx;

  // Deselected and serial clock parked low before the first frame.
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rx = 128'h0;
  end

  // One serial half period, counted on falling system edges.
  task half;
    begin
      repeat (4) @(negedge clk);
    end
  endtask

  // Sends nt bytes of tx MSB first, then clocks nb bytes in; zero is sent meanwhile.
  task frame(input [63:0] tx, input integer nt, input integer nb);
    integer i;
    begin
      cs_n = 1'b0;
      half;
      for (i = 0; i < 8 * (nt + nb); i = i + 1)
      begin
        mosi = (i < 8 * nt) ? tx[63 - i] : 1'b0;
        half;
        sclk = 1'b1;
        rx = {rx[126:0], miso};
        half;
        sclk = 1'b0;
      end
      half;
      cs_n = 1'b1;
      // The data line is not pulled, so show a changed level once released.
      mosi = ~mosi;
      half;
      half;
    end
  endtask
endmodule

// ---- testbench/secreg_checker.sv ----
/*
  Checker for the sequencer's status pins and output enable.
  Assumes it is bound to secreg_flash and sees only its ports.
*/
`timescale 1ns/1ns
`include "secreg_consts.vh"
module secreg_checker (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire miso_oe,
  input wire write_in_progress,
  input wire write_enable_latch,
  input wire security_lock_bit,
  input wire deep_power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since chip select went high; saturates so that it never wraps.
  reg [7:0] hi_cnt;
  always @(posedge clk or posedge rst)
    if (rst)
      hi_cnt <= 8'h00;
    else if (!cs_n)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF)
      hi_cnt <= hi_cnt + 8'h01;

  // ****************
  // Sequences and properties
  // ****************
  sequence s_busy;
    write_in_progress [*8];
  endsequence
  sequence s_idle_bus;
    cs_n [*6];
  endsequence

  property p_reset_standby;
    $fell(rst) |-> !deep_power_down && !write_in_progress;
  endproperty
  property p_wip_start;
    $rose(write_in_progress) |-> cs_n && $past(write_enable_latch);
  endproperty
  property p_wip_min;
    $rose(write_in_progress) |-> s_busy;
  endproperty
  property p_wip_max;
    $rose(write_in_progress) |-> ##[1:60] !write_in_progress;
  endproperty
  property p_wel_clear;
    $fell(write_in_progress) |-> !write_enable_latch;
  endproperty
  property p_lock_sticky;
    security_lock_bit |=> security_lock_bit;
  endproperty
  property p_lock_blocks;
    security_lock_bit |=> !$rose(write_in_progress);
  endproperty
  property p_dp_entry;
    $rose(deep_power_down) |-> hi_cnt >= `DP_ENTRY_CYC && !write_in_progress;
  endproperty
  property p_dp_ignores;
    deep_power_down |=> !$rose(write_enable_latch);
  endproperty
  property p_dp_release;
    $fell(deep_power_down) |-> cs_n;
  endproperty
  property p_oe_idle;
    s_idle_bus |-> !miso_oe;
  endproperty

  // ****************
  // Assertions
  // ****************
  a_reset_standby: assert property (p_reset_standby)
    else $error("not in standby after reset");
  a_wip_start: assert property (p_wip_start)
    else $error("cycle started without latch or deselect");
  a_wip_min: assert property (p_wip_min)
    else $error("busy flag too short");
  a_wip_max: assert property (p_wip_max)
    else $error("busy flag never cleared");
  a_wel_clear: assert property (p_wel_clear)
    else $error("write enable latch still set");
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock bit cleared");
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("cycle started while locked");
  a_dp_entry: assert property (p_dp_entry)
    else $error("power-down entered early or while busy");
  a_dp_ignores: assert property (p_dp_ignores)
    else $error("command acted in power-down");
  a_dp_release: assert property (p_dp_release)
    else $error("power-down left while selected");
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
endmodule

bind secreg_flash secreg_checker u_chk (
  .clk                (clk),
  .rst                (rst),
  .cs_n               (cs_n),
  .miso_oe            (miso_oe),
  .write_in_progress  (write_in_progress),
  .write_enable_latch (write_enable_latch),
  .security_lock_bit  (security_lock_bit),
  .deep_power_down    (deep_power_down)
);

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the security-space and power-down sequencer.
  Assumes the host model in spi_host_model.sv and the bound checker.
*/
`timescale 1ns/1ns
module tb_top;
  localparam [127:0] UID = 128'hC0FFEE0011223344556677889900AABB; // Arbitrary value.
  localparam [7:0]   DID = 8'hC3;                                  // Arbitrary value.
  reg     clk;
  reg     rst;
  reg     lock_set;
  wire    cs_n, sclk, mosi, miso, miso_oe;
  wire    write_in_progress, write_enable_latch, security_lock_bit, deep_power_down;
  integer n_fail;
  integer checked;

  secreg_flash #(.UNIQUE_ID(UID), .DEVICE_ID(DID)) u_dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .lock_set(lock_set), .miso(miso), .miso_oe(miso_oe),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
    .security_lock_bit(security_lock_bit), .deep_power_down(deep_power_down)
  );
  spi_host_model u_host (
    .clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi)
  );

  // 20 MHz system clock.
  always #25 clk = ~clk;

  task check(input [8*12-1:0] what, input [127:0] got, input [127:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (n_fail == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Waits for the self-timed cycle to end, bounded so a stuck flag is caught.
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (write_in_progress !== 1'b0 && n < 200)
      begin
        @(negedge clk);
        n = n + 1;
      end
      check("wip_end", n < 200, 1'b1);
    end
  endtask

  // Programs across a page end, then reads across the space end.
  task t_program;
    begin
      u_host.frame({8'h06, 56'h0}, 1, 0);
      u_host.frame({8'h42, 24'h0001FF, 8'h3C, 8'h5A, 16'h0}, 6, 0);
      check("wip_pgm", write_in_progress, 1'b1);
      wait_idle;
      check("wel_pgm", write_enable_latch, 1'b0);
      u_host.frame({8'h48, 24'h0001FF, 32'h0}, 5, 2);
      check("rd_wrap", u_host.rx[15:0], 16'h3CFF);
      u_host.frame({8'h48, 24'h000100, 32'h0}, 5, 1);
      check("rd_page", u_host.rx[7:0], 8'h5A);
    end
  endtask

  // An erase with a stray byte is discarded; a proper one clears the space.
  task t_erase;
    begin
      u_host.frame({8'h06, 56'h0}, 1, 0);
      u_host.frame({8'h44, 24'h0, 8'hAA, 24'h0}, 5, 0);
      check("wip_bad", write_in_progress, 1'b0);
      u_host.frame({8'h06, 56'h0}, 1, 0);
      u_host.frame({8'h44, 24'h000155, 32'h0}, 4, 0);
      check("wip_ers", write_in_progress, 1'b1);
      wait_idle;
      check("wel_ers", write_enable_latch, 1'b0);
      u_host.frame({8'h48, 24'h0001FF, 32'h0}, 5, 2);
      check("rd_erased", u_host.rx[15:0], 16'hFFFF);
    end
  endtask

  // Power-down entry, ignored commands, release and identifier readout.
  task t_power;
    begin
      u_host.frame({8'hB9, 8'h00, 48'h0}, 2, 0);
      repeat (70) @(negedge clk);
      check("dp_long", deep_power_down, 1'b0);
      u_host.frame({8'hB9, 56'h0}, 1, 0);
      check("dp_early", deep_power_down, 1'b0);
      repeat (70) @(negedge clk);
      check("dp_on", deep_power_down, 1'b1);
      u_host.frame({8'h06, 56'h0}, 1, 0);
      check("wel_dp", write_enable_latch, 1'b0);
      u_host.frame({8'hAB, 56'h0}, 1, 0);
      check("dp_off", deep_power_down, 1'b0);
      repeat (70) @(negedge clk);
      u_host.frame({8'hAB, 24'h0, 32'h0}, 4, 2);
      check("dev_id", u_host.rx[15:0], {DID, DID});
    end
  endtask

  // Release with ID straight out of power-down, then a reset in mid-run while powered down.
  task t_reset;
    begin
      u_host.frame({8'hB9, 56'h0}, 1, 0);
      repeat (70) @(negedge clk);
      check("dp_on2", deep_power_down, 1'b1);
      u_host.frame({8'hAB, 24'h0, 32'h0}, 4, 1);
      check("id_rel", u_host.rx[7:0], DID);
      check("dp_rel", deep_power_down, 1'b0);
      repeat (70) @(negedge clk);
      u_host.frame({8'hB9, 56'h0}, 1, 0);
      repeat (70) @(negedge clk);
      check("dp_on3", deep_power_down, 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      check("dp_rst", deep_power_down, 1'b0);
    end
  endtask

  // Once locked, program and erase leave the contents alone.
  task t_lock;
    begin
      lock_set = 1'b1;
      repeat (6) @(negedge clk);
      check("lock", security_lock_bit, 1'b1);
      u_host.frame({8'h06, 56'h0}, 1, 0);
      u_host.frame({8'h42, 24'h0, 8'h00, 24'h0}, 5, 0);
      check("wip_lpgm", write_in_progress, 1'b0);
      u_host.frame({8'h44, 24'h0, 32'h0}, 4, 0);
      check("wip_lers", write_in_progress, 1'b0);
      u_host.frame({8'h48, 24'h0, 32'h0}, 5, 1);
      check("rd_lock", u_host.rx[7:0], 8'hFF);
    end
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    lock_set = 1'b0;
    n_fail = 0;
    checked = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("standby", {deep_power_down, write_in_progress, write_enable_latch}, 3'h0);
    u_host.frame({8'h4B, 24'h0, 8'h00, 24'h0}, 5, 16);
    check("uid", u_host.rx, UID);
    t_program;
    t_erase;
    t_power;
    t_reset;
    t_lock;
    report_and_stop;
  end

  // A hang is cut short well past the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule
